/* hdl/rbc_defines.svh */
// Timing constants and reset values for the reset and brownout controller.
// Assumes the includer works on a 250 MHz reference clock.
`ifndef RBC_DEFINES_SVH
`define RBC_DEFINES_SVH
`define RBC_CLK_MHZ          250
`define RBC_EXT_MIN_OSC      8
`define RBC_STARTUP_MS       64
`define RBC_STARTUP_REF_MHZ  4
`define RBC_STARTUP_EXTRA    7
`define RBC_STARTUP_CYC      ((`RBC_STARTUP_MS * 1000 * `RBC_CLK_MHZ) + `RBC_STARTUP_EXTRA)
`define RBC_GLITCH_NS        50
`define RBC_CLK_PERIOD_NS    4
`define RBC_GLITCH_CYC       ((`RBC_GLITCH_NS / `RBC_CLK_PERIOD_NS) + 1)
`define RBC_CTRL_RESET       2'h0
`define RBC_CTRL_EN_BIT      0
`define RBC_CTRL_SEL_BIT     1
`endif

/* hdl/rbc_pkg.sv */
// Types shared by the reset and brownout controller.
// Assumes nothing beyond a SystemVerilog compiler.
package rbc_pkg;
    typedef enum logic [1:0] {
        RBC_HOLD  = 2'b00,
        RBC_WAIT  = 2'b01,
        RBC_RUN   = 2'b10
    } rbc_state_t;

    typedef struct packed {
        logic fail_reset_select;
        logic detect_disable;
    } rbc_ctrl_t;
endpackage : rbc_pkg

/* hdl/rbc_top.sv */
// Internal reset generator with external reset qualifier and power-fail supervisor.
// Assumes ref_clk stands for the oscillator; comparator and pin inputs are asynchronous.
`timescale 1ns/100ps
`include "rbc_defines.svh"

// Operation
// - Start-up delay 64 ms plus seven clocks.
// - Reset leaves data RAM untouched.
// - Detector active when enable bit zero.
// - Dips must persist beyond 50 ns.
// - Fail reset only when select bit requests.
// - Threshold fixed by one-time configuration bit.
// - Any reset restores control register defaults.
module rbc_top #(
    parameter int unsigned STARTUP_CYC = `RBC_STARTUP_CYC,
    parameter int unsigned EXT_MIN_CYC = `RBC_EXT_MIN_OSC,
    parameter int unsigned GLITCH_CYC  = `RBC_GLITCH_CYC
) (
    input  wire logic          ref_clk,
    input  wire logic          arst_n,
    input  wire logic          ext_reset_n,
    input  wire logic          supply_below_hi,
    input  wire logic          supply_below_lo,
    input  wire logic          fail_threshold_select,
    input  wire logic          ctrl_wr,
    input  wire logic [1:0]    ctrl_wdata,
    output logic      [1:0]    power_fail_control_reg,
    output logic               core_reset_n,
    output logic               power_fail_seen
);
    rbc_pkg::rbc_state_t state_reg;
    rbc_pkg::rbc_state_t state_next;
    rbc_pkg::rbc_ctrl_t  ctrl_reg;
    rbc_pkg::rbc_ctrl_t  ctrl_next;
    logic [1:0]          ext_sync_reg;
    logic [1:0]          hi_sync_reg;
    logic [1:0]          lo_sync_reg;
    logic [3:0]          ext_cnt_reg;
    logic [3:0]          ext_cnt_next;
    logic [7:0]          dip_cnt_reg;
    logic [7:0]          dip_cnt_next;
    logic [31:0]         start_cnt_reg;
    logic [31:0]         start_cnt_next;
    logic                ext_ok;
    logic                below;
    logic                fail_q;
    logic                any_reset;
    logic                core_reset_next;

    // Run state decode, shared by write gate and core release
    function automatic logic in_run(input rbc_pkg::rbc_state_t s);
        return (s == rbc_pkg::RBC_RUN);
    endfunction : in_run

    // Saturating step; a held fault must not wrap back to idle
    function automatic logic [7:0] sat_step(input logic [7:0] cnt, input logic [7:0] lim);
        logic [7:0] res;
        res = cnt;
        if (cnt < lim) begin
            res = cnt + 8'h01;
        end
        return res;
    endfunction : sat_step

    // End of the start-up count
    function automatic logic startup_done(input logic [31:0] cnt);
        return (cnt >= 32'(STARTUP_CYC - 1));
    endfunction : startup_done

    // External reset pin; idles high so no false low after reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_sync_reg <= 2'h3;
        end else begin
            ext_sync_reg <= {ext_sync_reg[0], ext_reset_n};
        end
    end

    // Upper range comparator; first stage read only by second
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_sync_reg <= 2'h0;
        end else begin
            hi_sync_reg <= {hi_sync_reg[0], supply_below_hi};
        end
    end

    // Lower range comparator
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lo_sync_reg <= 2'h0;
        end else begin
            lo_sync_reg <= {lo_sync_reg[0], supply_below_lo};
        end
    end

    // Low run counter; shorter pulses are not accepted
    always_comb begin
        ext_cnt_next = ext_cnt_reg;
        if (ext_sync_reg[1]) begin
            ext_cnt_next = 4'h0;
        end else begin
            ext_cnt_next = 4'(sat_step({4'h0, ext_cnt_reg}, 8'(EXT_MIN_CYC)));
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_cnt_reg <= 4'h0;
        end else begin
            ext_cnt_reg <= ext_cnt_next;
        end
    end
    assign ext_ok = (ext_cnt_reg >= 4'(EXT_MIN_CYC));

    // OTP bit picks comparator; no run-time path changes it
    assign below = fail_threshold_select ? lo_sync_reg[1] : hi_sync_reg[1];

    // Dip filter; also off while detector disabled
    always_comb begin
        dip_cnt_next = dip_cnt_reg;
        if (!below || ctrl_reg.detect_disable) begin
            dip_cnt_next = 8'h00;
        end else begin
            dip_cnt_next = sat_step(dip_cnt_reg, 8'(GLITCH_CYC));
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dip_cnt_reg <= 8'h00;
        end else begin
            dip_cnt_reg <= dip_cnt_next;
        end
    end

    assign fail_q = (dip_cnt_reg >= 8'(GLITCH_CYC)) && !ctrl_reg.detect_disable;
    assign power_fail_seen = fail_q;

    // Either source restarts the whole start-up
    assign any_reset = ext_ok || (fail_q && ctrl_reg.fail_reset_select);

    // Control register; defaults restored by every reset source
    always_comb begin
        ctrl_next = ctrl_reg;
        if (any_reset) begin
            ctrl_next = `RBC_CTRL_RESET;
        end else if (ctrl_wr && in_run(state_reg)) begin
            ctrl_next.fail_reset_select = ctrl_wdata[`RBC_CTRL_SEL_BIT];
            ctrl_next.detect_disable    = ctrl_wdata[`RBC_CTRL_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= `RBC_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign power_fail_control_reg = {ctrl_reg.fail_reset_select, ctrl_reg.detect_disable};

    // Sequencer; no RAM here, data memory is never cleared
    always_comb begin
        state_next     = state_reg;
        start_cnt_next = start_cnt_reg;
        if (any_reset) begin
            state_next     = rbc_pkg::RBC_HOLD;
            start_cnt_next = 32'h0000_0000;
        end else begin
            unique case (state_reg)
                rbc_pkg::RBC_HOLD: begin
                    state_next     = rbc_pkg::RBC_WAIT;
                    start_cnt_next = 32'h0000_0000;
                end
                rbc_pkg::RBC_WAIT: begin
                    if (startup_done(start_cnt_reg)) begin
                        state_next = rbc_pkg::RBC_RUN;
                    end else begin
                        start_cnt_next = start_cnt_reg + 32'h0000_0001;
                    end
                end
                rbc_pkg::RBC_RUN: begin
                    state_next = rbc_pkg::RBC_RUN;
                end
                default: begin
                    state_next = rbc_pkg::RBC_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= rbc_pkg::RBC_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // Wide counter kept in its own process
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_cnt_reg <= 32'h0000_0000;
        end else begin
            start_cnt_reg <= start_cnt_next;
        end
    end

    // Registered release; a new reset drops it on the next edge
    assign core_reset_next = in_run(state_reg) && !any_reset;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            core_reset_n <= 1'b0;
        end else begin
            core_reset_n <= core_reset_next;
        end
    end
endmodule : rbc_top

/* tb/rbc_checker_asserts.sv */
// Port checker for rbc_top.
// Assumes it is bound onto rbc_top.
`timescale 1ns/100ps
module rbc_checker #(
    parameter int unsigned STARTUP_CYC = 20,
    parameter int unsigned GLITCH_CYC  = 13
) (
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic       ext_reset_n,
    input wire logic       supply_below_hi,
    input wire logic       supply_below_lo,
    input wire logic       fail_threshold_select,
    input wire logic [1:0] power_fail_control_reg,
    input wire logic       core_reset_n,
    input wire logic       power_fail_seen
);
    int unsigned low_cnt_reg;
    int unsigned dip_cnt_reg;
    logic        dip;
    assign dip = fail_threshold_select ? supply_below_lo : supply_below_hi;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) low_cnt_reg <= 0;
        else low_cnt_reg <= core_reset_n ? 0 : low_cnt_reg + 1;
    end
    // Counts the selected comparator only, so a wrong choice never qualifies
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) dip_cnt_reg <= 0;
        else dip_cnt_reg <= dip ? dip_cnt_reg + 1 : 0;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence ext_held;
        (!ext_reset_n)[*8] ##1 (!ext_reset_n)[*4];
    endsequence
    sequence quiet;
        ext_reset_n[*3];
    endsequence
    a_ext_taken: assert property (ext_held |-> ##[0:3] !core_reset_n)
        else $error("external reset not taken");
    a_startup_len: assert property ($rose(core_reset_n) |-> low_cnt_reg >= STARTUP_CYC)
        else $error("start-up too short");
    a_reset_held: assert property ($fell(core_reset_n) |=> (!core_reset_n)[*8])
        else $error("core reset not held");
    a_ctrl_cleared: assert property ($fell(core_reset_n) |=> power_fail_control_reg == 2'h0)
        else $error("control not cleared");
    a_dis_quiet: assert property (quiet ##0 (core_reset_n && power_fail_control_reg[0]) |=>
        core_reset_n)
        else $error("disabled detector reset core");
    a_sel_quiet: assert property (quiet ##0 (core_reset_n && !power_fail_control_reg[1]) |=>
        core_reset_n)
        else $error("unselected fail reset core");
    a_dip_len: assert property ($rose(power_fail_seen) |-> dip_cnt_reg >= GLITCH_CYC)
        else $error("short dip qualified");
    a_fail_reset: assert property ($rose(power_fail_seen) && power_fail_control_reg == 2'h2 |->
        ##[0:3] !core_reset_n)
        else $error("fail gave no reset");
endmodule : rbc_checker
bind rbc_top rbc_checker #(.STARTUP_CYC(STARTUP_CYC), .GLITCH_CYC(GLITCH_CYC)) rbc_checker_i (.*);

/* tb/rbc_rail_model.sv */
// Reset driver and supply rail model.
// Assumes its task is called at a falling edge of ref_clk.
`timescale 1ns/100ps
module rbc_rail_model (
    input  wire logic ref_clk,
    output logic      ext_reset_n,
    output logic      supply_below_hi,
    output logic      supply_below_lo
);
    initial {ext_reset_n, supply_below_hi, supply_below_lo} = 3'h4;
    // Holds the level n cycles; accepted resets use n of 8 or more
    task automatic hold(input logic [2:0] lvl, input int n);
        {ext_reset_n, supply_below_hi, supply_below_lo} = lvl;
        repeat (n) @(negedge ref_clk);
        {ext_reset_n, supply_below_hi, supply_below_lo} = 3'h4;
    endtask : hold
endmodule : rbc_rail_model

/* tb/tb_rbc_top.sv */
// Bench for rbc_top with rail model.
// Assumes a short start-up count.
`timescale 1ns/100ps
module tb_rbc_top;
    logic       ref_clk, arst_n, fail_threshold_select, ctrl_wr, core_reset_n, power_fail_seen;
    logic       ext_reset_n, supply_below_hi, supply_below_lo;
    logic [1:0] ctrl_wdata, power_fail_control_reg;
    int         errors = 0, checks_done = 0;
    rbc_top #(.STARTUP_CYC(20)) rbc_top_i (.*);
    rbc_rail_model rbc_rail_model_i (.*);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic check(input string name, input logic [1:0] exp, input logic [1:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic startup(input int lo, input int hi);
        int n = 0;
        while (core_reset_n !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        check("startup", 2'h1, {1'b0, n >= lo && n <= hi});
        if (n >= 100)
            report_and_stop();
    endtask : startup
    task automatic write(input logic [1:0] v);
        ctrl_wdata = v;
        ctrl_wr = 1'b1;
        @(negedge ref_clk);
        ctrl_wr = 1'b0;
        @(negedge ref_clk);
        check("ctrl", v, power_fail_control_reg);
    endtask : write
    task automatic ext_case(input int n, input logic hit);
        write(2'h3);
        rbc_rail_model_i.hold(3'h0, n);
        check("core_reset_n", {1'b0, !hit}, {1'b0, core_reset_n});
        check("ctrl", hit ? 2'h0 : 2'h3, power_fail_control_reg);
        if (hit)
            startup(20, 32);
    endtask : ext_case
    // Fail reset lands mid-hold, so the remaining start-up is shorter
    task automatic fail_case(input logic [1:0] c, input logic t, input logic [2:0] l, input int n,
        input logic hit, input logic seen);
        fail_threshold_select = t;
        write(c);
        rbc_rail_model_i.hold(l, n);
        check("power_fail_seen", {1'b0, seen}, {1'b0, power_fail_seen});
        repeat (3) @(negedge ref_clk);
        check("core_reset_n", {1'b0, !hit}, {1'b0, core_reset_n});
        if (hit)
            startup(8, 14);
    endtask : fail_case
    initial begin
        {arst_n, fail_threshold_select, ctrl_wr, ctrl_wdata} = 5'h00;
        repeat (4) @(negedge ref_clk);
        arst_n = 1'b1;
        startup(20, 32);
        check("ctrl", 2'h0, power_fail_control_reg);
        ext_case(7, 1'b0);
        ext_case(14, 1'b1);
        fail_case(2'h2, 1'b0, 3'h6, 10, 1'b0, 1'b0);
        fail_case(2'h2, 1'b0, 3'h6, 24, 1'b1, 1'b1);
        fail_case(2'h2, 1'b1, 3'h6, 24, 1'b0, 1'b0);
        fail_case(2'h2, 1'b1, 3'h5, 24, 1'b1, 1'b1);
        fail_case(2'h3, 1'b0, 3'h6, 24, 1'b0, 1'b0);
        fail_case(2'h0, 1'b0, 3'h6, 24, 1'b0, 1'b1);
        report_and_stop();
    end
endmodule : tb_rbc_top
